/* File: rtl/slg_gate.sv */
// Purpose: Security lock state and per-command execute/abort verdict
// Assumes: Nonvolatile settings arrive on nv_*_i and are saved via nv_we_o
// Notes:   Verdict returned one cycle after req_valid_i, as a pulse
//
// Notes on behaviour
// - Six security commands are accepted.
// - Word 128 reports security support.
// - Factory master set, lock disabled.
// - Master replacement keeps lock-enable unchanged.
// - User password set means locked after reset.
// - Locked rejects media commands until unlock.
// - High level: master password unlocks.
// - Maximum level: master serves erase-unit and disable, not unlock.
// - Each failed unlock decrements attempt counter.
// - Counter zero sets flag, aborts unlock/erase.
// - Reset clears flag, reloads counter five.
// - Locked aborts media, disable, freeze, set.
`timescale 1ns/1ps

module slg_gate (
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  req_valid_i,
    input  wire slg_pkg::slg_req_s     req_i,
    input  wire logic                  nv_valid_i,
    input  wire logic                  nv_lock_en_i,
    input  wire logic                  nv_level_max_i,
    input  wire logic [15:0]           nv_user_pw_i,
    input  wire logic [15:0]           nv_master_pw_i,
    output logic                       rsp_valid_o,
    output slg_pkg::slg_rsp_s          rsp_o,
    output logic                       nv_we_o,
    output logic                       nv_lock_en_o,
    output logic                       nv_level_max_o,
    output logic [15:0]                nv_user_pw_o,
    output logic [15:0]                nv_master_pw_o,
    output logic [15:0]                id_word_o,
    output logic [2:0]                 attempts_o,
    output logic                       unlock_attempts_exhausted_flag_o
);

    ////////////////////////////////////////////////////////////////////////
    // State
    ////////////////////////////////////////////////////////////////////////

    slg_pkg::slg_state_e state_r;       // Lock state
    logic        lock_en_r;             // User password set, lock enabled
    logic        level_max_r;           // Maximum security level
    logic [15:0] user_pw_r;             // User token
    logic [15:0] master_pw_r;           // Master token
    logic [2:0]  attempts_r;            // Remaining unlock attempts
    logic        expired_r;             // Attempts exhausted
    logic        load_pend_r;           // Settings not yet taken from store
    logic        nv_we_r;               // Save pulse to the store
    logic        rsp_valid_r;           // Verdict strobe
    slg_pkg::slg_rsp_s rsp_r;           // Verdict data

    // Decoded verdict terms, combinational
    logic pw_ok;        // Token matches the selected password
    logic allowed;      // State table permits command
    logic fail_unlock;  // Unlock attempt that fails
    logic ok_unlock;    // Unlock attempt that succeeds
    logic ok_erase;     // Erase unit that succeeds

    ////////////////////////////////////////////////////////////////////////
    // Decode
    ////////////////////////////////////////////////////////////////////////

    // State table of executable commands per lock state
    function automatic logic permit(input slg_pkg::slg_state_e st,
                                    input slg_pkg::slg_cmd_e   c);
        logic p;
        p = 1'b1;
        unique case (st)
            slg_pkg::SLG_ST_LOCKED:
                p = !(c == slg_pkg::SLG_CMD_MEDIA  ||
                      c == slg_pkg::SLG_CMD_DIS_PW ||
                      c == slg_pkg::SLG_CMD_FREEZE ||
                      c == slg_pkg::SLG_CMD_SET_PW);
            slg_pkg::SLG_ST_FROZEN:
                p = !(c == slg_pkg::SLG_CMD_DIS_PW    ||
                      c == slg_pkg::SLG_CMD_ERASE_UNT ||
                      c == slg_pkg::SLG_CMD_SET_PW    ||
                      c == slg_pkg::SLG_CMD_UNLOCK);
            slg_pkg::SLG_ST_UNLOCKED:
                p = 1'b1;
            default: p = 1'b0;
        endcase
        return p;
    endfunction

    always_comb
    begin
        pw_ok   = req_i.use_master ? (req_i.token == master_pw_r)
                                   : (req_i.token == user_pw_r);
        allowed = permit(state_r, req_i.cmd);
        // Exhausted counter blocks unlock and erase outright
        if (expired_r && (req_i.cmd == slg_pkg::SLG_CMD_UNLOCK ||
                          req_i.cmd == slg_pkg::SLG_CMD_ERASE_UNT))
        begin
            allowed = 1'b0;
        end
        // Maximum level: master alone never unlocks
        ok_unlock   = allowed && req_i.cmd == slg_pkg::SLG_CMD_UNLOCK &&
                      pw_ok && !(req_i.use_master && level_max_r);
        fail_unlock = allowed && req_i.cmd == slg_pkg::SLG_CMD_UNLOCK &&
                      !ok_unlock;
        ok_erase    = allowed && req_i.cmd == slg_pkg::SLG_CMD_ERASE_UNT &&
                      pw_ok;
    end

    ////////////////////////////////////////////////////////////////////////
    // Lock state
    ////////////////////////////////////////////////////////////////////////

    // Reset lands in unlocked; the settings load then goes to locked when a user password is enabled
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            state_r <= slg_pkg::SLG_ST_UNLOCKED;
        end
        else if (load_pend_r && nv_valid_i)
        begin
            state_r <= nv_lock_en_i ? slg_pkg::SLG_ST_LOCKED
                                    : slg_pkg::SLG_ST_UNLOCKED;
        end
        // A request answered abort during the load must leave no trace
        else if (req_valid_i && !load_pend_r)
        begin
            if (ok_unlock || ok_erase)
            begin
                state_r <= slg_pkg::SLG_ST_UNLOCKED;
            end
            else if (allowed && req_i.cmd == slg_pkg::SLG_CMD_FREEZE)
            begin
                state_r <= slg_pkg::SLG_ST_FROZEN;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Settings, loaded from and saved to nonvolatile store
    ////////////////////////////////////////////////////////////////////////

    // Register copy of the store; reset marks it stale and loads factory values
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            load_pend_r <= 1'b1;
            lock_en_r   <= 1'b0;
            level_max_r <= 1'b0;
            user_pw_r   <= 16'h0000;
            master_pw_r <= slg_pkg::MASTER_DEFAULT;
            nv_we_r     <= 1'b0;
        end
        else if (load_pend_r)
        begin
            // Hold off settings changes until the store answers
            nv_we_r <= 1'b0;
            if (nv_valid_i)
            begin
                load_pend_r <= 1'b0;
                lock_en_r   <= nv_lock_en_i;
                level_max_r <= nv_level_max_i;
                user_pw_r   <= nv_user_pw_i;
                master_pw_r <= nv_master_pw_i;
            end
        end
        else
        begin
            nv_we_r <= 1'b0;
            if (req_valid_i && allowed)
            begin
                unique case (req_i.cmd)
                    slg_pkg::SLG_CMD_SET_PW:
                    begin
                        nv_we_r <= 1'b1;
                        if (req_i.use_master)
                        begin
                            // Lock enable untouched
                            master_pw_r <= req_i.token;
                        end
                        else
                        begin
                            user_pw_r   <= req_i.token;
                            lock_en_r   <= 1'b1;
                            level_max_r <= req_i.level_max;
                        end
                    end
                    slg_pkg::SLG_CMD_DIS_PW:
                    begin
                        if (pw_ok)
                        begin
                            lock_en_r <= 1'b0;
                            nv_we_r   <= 1'b1;
                        end
                    end
                    slg_pkg::SLG_CMD_ERASE_UNT:
                    begin
                        if (pw_ok)
                        begin
                            lock_en_r <= 1'b0;
                            nv_we_r   <= 1'b1;
                        end
                    end
                    default:
                    begin
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Attempt counter and exhausted flag
    ////////////////////////////////////////////////////////////////////////

    // Volatile by design: a reset restores five tries
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            attempts_r <= slg_pkg::ATTEMPT_RELOAD;
            expired_r  <= 1'b0;
        end
        else if (req_valid_i && !load_pend_r && fail_unlock &&
                 attempts_r != slg_pkg::ATTEMPT_ZERO)
        begin
            attempts_r <= attempts_r - slg_pkg::ATTEMPT_ONE;
            if (attempts_r == slg_pkg::ATTEMPT_ONE)
            begin
                expired_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Verdict
    ////////////////////////////////////////////////////////////////////////

    // Registered answer; a request during settings load is aborted
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            rsp_valid_r <= 1'b0;
            rsp_r       <= '0;
        end
        else
        begin
            rsp_valid_r   <= req_valid_i;
            rsp_r.execute <= req_valid_i && !load_pend_r && allowed;
            rsp_r.abort   <= req_valid_i && (load_pend_r || !allowed);
            rsp_r.erase   <= req_valid_i && !load_pend_r && ok_erase;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    ////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        id_word_o                        = '0;
        id_word_o[slg_pkg::ID_BIT_SUPP]  = 1'b1;
        id_word_o[slg_pkg::ID_BIT_ENAB]  = lock_en_r;
        id_word_o[slg_pkg::ID_BIT_LOCKED] =
            (state_r == slg_pkg::SLG_ST_LOCKED);
        id_word_o[slg_pkg::ID_BIT_FROZEN] =
            (state_r == slg_pkg::SLG_ST_FROZEN);
        id_word_o[slg_pkg::ID_BIT_EXPIRED] = expired_r;
        id_word_o[slg_pkg::ID_BIT_LEVEL] = level_max_r;
    end

    assign rsp_valid_o     = rsp_valid_r;
    assign rsp_o           = rsp_r;
    assign nv_we_o         = nv_we_r;
    assign nv_lock_en_o    = lock_en_r;
    assign nv_level_max_o  = level_max_r;
    assign nv_user_pw_o    = user_pw_r;
    assign nv_master_pw_o  = master_pw_r;
    assign attempts_o      = attempts_r;
    assign unlock_attempts_exhausted_flag_o = expired_r;

endmodule // slg_gate

/* File: rtl/slg_pkg.sv */
// Purpose: Shared constants and types for the security lock command gate
// Assumes: Command classes are decoded upstream into a small class code
// Notes:   Passwords are 16-bit tokens here; wider storage lives elsewhere
package slg_pkg;

    // Password token width held by the gate
    localparam int PW_W = 16;

    // Attempt counter width and reload value after reset
    localparam logic [2:0] ATTEMPT_RELOAD = 3'h5;
    localparam logic [2:0] ATTEMPT_ZERO   = 3'h0;
    localparam logic [2:0] ATTEMPT_ONE    = 3'h1;

    // Identification word index and bit positions in it
    localparam logic [7:0] ID_WORD_SEC    = 8'h80;
    localparam int         ID_BIT_SUPP    = 0;
    localparam int         ID_BIT_ENAB    = 1;
    localparam int         ID_BIT_LOCKED  = 2;
    localparam int         ID_BIT_FROZEN  = 3;
    localparam int         ID_BIT_EXPIRED = 4;
    localparam int         ID_BIT_LEVEL   = 8;

    // Factory master token; value is arbitrary
    localparam logic [15:0] MASTER_DEFAULT = 16'h5A5A;

    // Class of the incoming command, decoded by the front end
    typedef enum logic [3:0] {
        SLG_CMD_OTHER     = 4'h0,   // Any non-media, non-security command
        SLG_CMD_MEDIA     = 4'h1,   // Format, read, write, verify forms
        SLG_CMD_SET_PW    = 4'h2,
        SLG_CMD_UNLOCK    = 4'h3,
        SLG_CMD_ERASE_PRE = 4'h4,
        SLG_CMD_ERASE_UNT = 4'h5,
        SLG_CMD_FREEZE    = 4'h6,
        SLG_CMD_DIS_PW    = 4'h7
    } slg_cmd_e;

    // Lock state, one-hot
    typedef enum logic [2:0] {
        SLG_ST_UNLOCKED = 3'b001,
        SLG_ST_LOCKED   = 3'b010,
        SLG_ST_FROZEN   = 3'b100
    } slg_state_e;

    // One command request from the task-file front end
    typedef struct packed {
        slg_cmd_e        cmd;        // Command class
        logic            use_master; // Token is the master password
        logic            level_max;  // Set password: maximum level
        logic [PW_W-1:0] token;      // Password supplied
    } slg_req_s;

    // Verdict on one command
    typedef struct packed {
        logic execute;  // Command may proceed
        logic abort;    // Command aborted
        logic erase;    // Erase of all user data requested
    } slg_rsp_s;

endpackage

/* File: verification/slg_gate_chk.sv */
// Purpose: Port assertions for the security lock command gate
// Assumes: Verdict pulses one cycle after each request
// Notes:   Lock state is read from identification word bits
`timescale 1ns/1ps

module slg_gate_chk (
    input wire logic              clk_i,
    input wire logic              rst_n_i,
    input wire logic              req_valid_i,
    input wire slg_pkg::slg_req_s req_i,
    input wire logic              rsp_valid_o,
    input wire slg_pkg::slg_rsp_s rsp_o,
    input wire logic [15:0]       id_word_o,
    input wire logic [2:0]        attempts_o,
    input wire logic              unlock_attempts_exhausted_flag_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    logic unl;  // Unlock request this cycle
    logic lk;   // Request the locked state refuses
    logic fz;   // Request the frozen state refuses
    logic ex;   // Request refused once tries run out
    assign unl = req_valid_i && req_i.cmd == slg_pkg::SLG_CMD_UNLOCK;
    assign lk = req_valid_i && req_i.cmd inside {slg_pkg::SLG_CMD_MEDIA,
        slg_pkg::SLG_CMD_DIS_PW, slg_pkg::SLG_CMD_FREEZE,
        slg_pkg::SLG_CMD_SET_PW};
    assign ex = unl || req_valid_i
        && req_i.cmd == slg_pkg::SLG_CMD_ERASE_UNT;
    assign fz = ex || req_valid_i && req_i.cmd inside
        {slg_pkg::SLG_CMD_DIS_PW, slg_pkg::SLG_CMD_SET_PW};

    ////////////////////////////////////////////////////////////////////
    a_rsp_one_cycle: assert property (
        rsp_valid_o == $past(req_valid_i)) else $error("verdict timing");
    a_verdict_one_kind: assert property (
        rsp_valid_o |-> rsp_o.execute != rsp_o.abort)
        else $error("verdict both or neither");
    a_support_bit: assert property (
        id_word_o[0]) else $error("support bit clear");
    a_flag_at_zero: assert property (
        unlock_attempts_exhausted_flag_o == (attempts_o == 3'h0)
        && id_word_o[4] == unlock_attempts_exhausted_flag_o)
        else $error("flag and counter disagree");
    a_reload_five: assert property (
        $rose(rst_n_i) |-> attempts_o == slg_pkg::ATTEMPT_RELOAD
        && !unlock_attempts_exhausted_flag_o) else $error("no reload");
    a_dec_by_one: assert property (
        $past(rst_n_i) && $changed(attempts_o) |-> $past(unl)
        && $past(attempts_o) != 3'h0
        && attempts_o == $past(attempts_o) - 3'h1)
        else $error("counter step wrong");
    a_locked_aborts: assert property (
        id_word_o[2] && lk |=> rsp_o.abort) else $error("locked ran");
    a_frozen_aborts: assert property (
        id_word_o[3] && fz |=> rsp_o.abort) else $error("frozen ran");
    a_expired_aborts: assert property (
        unlock_attempts_exhausted_flag_o && ex |=> rsp_o.abort)
        else $error("expired ran");
    a_max_master_fails: assert property (
        id_word_o[2] && id_word_o[8] && unl && req_i.use_master
        |=> id_word_o[2]) else $error("master unlocked at max");

    c_erase: cover property (rsp_valid_o && rsp_o.erase);
    c_expired: cover property ($rose(unlock_attempts_exhausted_flag_o));
    c_frozen_req: cover property (id_word_o[3] && fz);
endmodule // slg_gate_chk

bind slg_gate slg_gate_chk slg_gate_chk_inst (.clk_i, .rst_n_i,
    .req_valid_i, .req_i, .rsp_valid_o, .rsp_o, .id_word_o,
    .attempts_o, .unlock_attempts_exhausted_flag_o);

/* File: verification/slg_gate_tb_top.sv */
// Purpose: Self-checking bench for the security lock command gate
// Assumes: Store model raises nv_valid_i after every reset
// Notes:   Power cycles are modelled by pulsing rst_n_i
`timescale 1ns/1ps
`define CHK(n,e,g) begin comparisons++; if ((g) !== (e)) begin \
    err_total++; $display("unexpected %s exp %h got %h", n, e, g); end end

module slg_gate_tb_top;
    logic              clk_i = 1'b0;
    logic              rst_n_i = 1'b0;
    logic              req_valid_i = 1'b0;
    slg_pkg::slg_req_s req_i = '0;
    slg_pkg::slg_rsp_s rsp_o, exp_v, exp_q[$];   // Notes of verdicts
    logic              rsp_valid_o, nv_valid_i, nv_we_o, nv_lock_en_i;
    logic              nv_lock_en_o, nv_level_max_i, nv_level_max_o;
    logic [15:0]       nv_user_pw_i, nv_master_pw_i, nv_user_pw_o;
    logic [15:0]       nv_master_pw_o, id_word_o, usr, mst;
    logic [2:0]        attempts_o;
    logic              unlock_attempts_exhausted_flag_o;
    int                err_total = 0, comparisons = 0, cyc = 0;

    always #10 clk_i = ~clk_i;

    slg_gate slg_gate_inst (.clk_i, .rst_n_i, .req_valid_i, .req_i,
        .nv_valid_i, .nv_lock_en_i, .nv_level_max_i, .nv_user_pw_i,
        .nv_master_pw_i, .rsp_valid_o, .rsp_o, .nv_we_o, .nv_lock_en_o,
        .nv_level_max_o, .nv_user_pw_o, .nv_master_pw_o, .id_word_o,
        .attempts_o, .unlock_attempts_exhausted_flag_o);
    slg_nv_store slg_nv_store_inst (.clk_i, .rst_n_i, .we_i(nv_we_o),
        .lock_en_i(nv_lock_en_o), .level_max_i(nv_level_max_o),
        .user_pw_i(nv_user_pw_o), .master_pw_i(nv_master_pw_o),
        .valid_o(nv_valid_i), .lock_en_o(nv_lock_en_i),
        .level_max_o(nv_level_max_i), .user_pw_o(nv_user_pw_i),
        .master_pw_o(nv_master_pw_i));

    ////////////////////////////////////////////////////////////////////
    // Prints the verdict and ends the run
    task automatic print_verdict();
        `CHK("pending notes", 0, exp_q.size())
        if (err_total == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Issues one request; the strobe stays up for back-to-back use
    task automatic req(slg_pkg::slg_cmd_e c, logic m, logic lv,
                       logic [15:0] t, logic [2:0] e);
        @(posedge clk_i);
        #1;
        req_valid_i = 1'b1;
        req_i = '{c, m, lv, t};
        exp_q.push_back(slg_pkg::slg_rsp_s'(e));
    endtask

    // Drops the strobe after the last request is taken
    task automatic idle();
        @(posedge clk_i);
        #1;
        req_valid_i = 1'b0;
    endtask

    // Power cycle: reset for 12 cycles, then settings load
    task automatic power();
        @(posedge clk_i);
        #1;
        rst_n_i = 1'b0;
        repeat (12) @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        repeat (4) @(posedge clk_i);
        // Let the load edge settle before anything is looked at
        #1;
    endtask

    // Every class not skipped, random token; ab marks refusals
    task automatic sweep(logic [7:0] ab, logic [7:0] skip);
        for (int i = 0; i < 8; i++)
            if (!skip[i])
                req(slg_pkg::slg_cmd_e'(i), 1'b0, 1'b0, 16'($urandom),
                    ab[i] ? 3'b010 : 3'b100);
        idle();
    endtask

    ////////////////////////////////////////////////////////////////////
    // Compares each verdict with the oldest note
    always @(negedge clk_i)
    begin
        if (rsp_valid_o === 1'b1)
        begin
            exp_v = exp_q.pop_front();
            `CHK("verdict", exp_v, rsp_o)
        end
    end

    // Cuts a hang short
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            print_verdict();
        end
    end

    // Main sequence
    initial
    begin
        void'($urandom(12138));
        usr = 16'h8000 | 16'($urandom);
        mst = usr ^ 16'h00f0;
        power();
        `CHK("tries", slg_pkg::ATTEMPT_RELOAD, attempts_o)
        `CHK("supported", 1'b1, id_word_o[0])
        `CHK("master", slg_pkg::MASTER_DEFAULT, nv_master_pw_o)
        sweep(8'h00, 8'b1110_1100);
        req(slg_pkg::SLG_CMD_SET_PW, 1'b1, 1'b0, mst, 3'b100);
        idle();
        `CHK("lock enable", 1'b0, nv_lock_en_o)
        `CHK("master", mst, nv_master_pw_o)
        req(slg_pkg::SLG_CMD_SET_PW, 1'b0, 1'b0, usr, 3'b100);
        idle();
        `CHK("lock enable", 1'b1, nv_lock_en_o)
        `CHK("enabled bit", 1'b1, id_word_o[1])
        `CHK("user token", usr, nv_user_pw_o)
        power();
        `CHK("locked", 1'b1, id_word_o[2])
        sweep(8'b1100_0110, 8'b0010_1000);
        for (int i = 4; i >= 0; i--)
        begin
            req(slg_pkg::SLG_CMD_UNLOCK, 1'b0, 1'b0, ~usr, 3'b100);
            idle();
            `CHK("tries", 3'(i), attempts_o)
        end
        `CHK("expired", 1'b1, id_word_o[4])
        req(slg_pkg::SLG_CMD_UNLOCK, 1'b0, 1'b0, usr, 3'b010);
        req(slg_pkg::SLG_CMD_ERASE_UNT, 1'b1, 1'b0, mst, 3'b010);
        idle();
        `CHK("tries", 3'h0, attempts_o)
        `CHK("locked", 1'b1, id_word_o[2])
        power();
        `CHK("expired", 1'b0, id_word_o[4])
        req(slg_pkg::SLG_CMD_UNLOCK, 1'b1, 1'b0, mst, 3'b100);
        idle();
        `CHK("locked", 1'b0, id_word_o[2])
        sweep(8'h00, 8'b1110_1100);
        req(slg_pkg::SLG_CMD_FREEZE, 1'b0, 1'b0, usr, 3'b100);
        idle();
        `CHK("frozen", 1'b1, id_word_o[3])
        sweep(8'b1010_1100, 8'h00);
        power();
        req(slg_pkg::SLG_CMD_UNLOCK, 1'b0, 1'b0, usr, 3'b100);
        req(slg_pkg::SLG_CMD_SET_PW, 1'b0, 1'b1, usr, 3'b100);
        idle();
        power();
        `CHK("max level", 1'b1, id_word_o[8])
        req(slg_pkg::SLG_CMD_UNLOCK, 1'b1, 1'b0, mst, 3'b100);
        idle();
        `CHK("tries", 3'h4, attempts_o)
        `CHK("locked", 1'b1, id_word_o[2])
        req(slg_pkg::SLG_CMD_ERASE_UNT, 1'b1, 1'b0, mst, 3'b101);
        idle();
        `CHK("locked", 1'b0, id_word_o[2])
        `CHK("lock enable", 1'b0, nv_lock_en_o)
        repeat (2) @(posedge clk_i);
        print_verdict();
    end
endmodule // slg_gate_tb_top

/* File: verification/slg_nv_store.sv */
// Purpose: Settings store model on the far side of the save port
// Assumes: Contents outlive rst_n_i, which stands for power cycles
// Notes:   Data lines are garbage until valid rises after reset
`timescale 1ns/1ps

module slg_nv_store (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        we_i,
    input  wire logic        lock_en_i,
    input  wire logic        level_max_i,
    input  wire logic [15:0] user_pw_i,
    input  wire logic [15:0] master_pw_i,
    output logic             valid_o,
    output logic             lock_en_o,
    output logic             level_max_o,
    output logic [15:0]      user_pw_o,
    output logic [15:0]      master_pw_o
);
    logic [1:0]  wait_r;                           // Cycles since reset
    logic        lk_r  = 1'b0;                     // Lock off
    logic        lv_r  = 1'b0;                     // High level
    logic [15:0] usr_r = 16'h0000;                 // No user token
    logic [15:0] mst_r = slg_pkg::MASTER_DEFAULT;  // Factory

    // Saves settings; reset never touches them
    always @(posedge clk_i)
    begin
        if (we_i)
        begin
            lk_r  <= lock_en_i;
            lv_r  <= level_max_i;
            usr_r <= user_pw_i;
            mst_r <= master_pw_i;
        end
    end

    // Valid rises three edges after reset, so the gate must wait
    always @(posedge clk_i)
    begin
        if (!rst_n_i)
            wait_r <= 2'h0;
        else if (wait_r != 2'h3)
            wait_r <= wait_r + 2'h1;
    end

    // Inverted data until valid so a stale sample cannot pass
    assign valid_o     = (wait_r == 2'h3);
    assign lock_en_o   = valid_o ? lk_r : ~lk_r;
    assign level_max_o = valid_o ? lv_r : ~lv_r;
    assign user_pw_o   = valid_o ? usr_r : ~usr_r;
    assign master_pw_o = valid_o ? mst_r : ~mst_r;
endmodule // slg_nv_store
